// ### hdl/agf_pkg.sv
// Purpose: shared constants and types for the address generator and fetch trap
// Assumes: 8-bit data, 16-bit addresses
// Notes: opcode decode covers only the groups this block needs
package agf_pkg;
  localparam logic [15:0] TRAP_VEC_HI = 16'hFFEE;
  localparam logic [15:0] TRAP_VEC_LO = 16'hFFEF;
  localparam logic [15:0] REG_SPACE_LO = 16'h0000;
  localparam logic [15:0] REG_SPACE_HI = 16'h001F;
  localparam logic [15:0] RESET_VEC = 16'hFFFE;
  localparam logic [1:0] MASK_WINDOW_CYC = 2'h2;
  localparam logic [7:0] OP_CLI = 8'h0E;
  localparam logic [7:0] OP_SEI = 8'h0F;
  localparam logic [7:0] OP_TAP = 8'h06;
  localparam logic [7:0] OP_LDS_IMM = 8'h8E;
  localparam logic [7:0] OP_LDX_IMM = 8'hCE;
  localparam logic [7:0] OP_AIM_IDX = 8'h61;
  localparam logic [7:0] OP_OIM_IDX = 8'h62;
  localparam logic [7:0] OP_EIM_IDX = 8'h65;
  localparam logic [7:0] OP_TIM_IDX = 8'h6B;
  localparam logic [7:0] OP_AIM_DIR = 8'h71;
  localparam logic [7:0] OP_OIM_DIR = 8'h72;
  localparam logic [7:0] OP_EIM_DIR = 8'h75;
  localparam logic [7:0] OP_TIM_DIR = 8'h7B;
  localparam int STACK_BYTES = 7;

  typedef enum logic [2:0] {
    AM_ACC = 3'h0,
    AM_IMM = 3'h1,
    AM_DIR = 3'h2,
    AM_EXT = 3'h3,
    AM_IDX = 3'h4,
    AM_INH = 3'h5,
    AM_REL = 3'h6,
    AM_BAD = 3'h7
  } agf_mode_t;

  typedef struct packed {
    agf_mode_t mode;
    logic [1:0] len;
    logic acc_b;
    logic wide_imm;
    logic bitop;
  } agf_dec_t;

  typedef struct packed {
    logic req;
    logic [15:0] addr;
    logic fetch;
    logic wr;
    logic [7:0] wdata;
  } agf_bus_t;
endpackage : agf_pkg

// ### hdl/agf_decode.sv
// Purpose: opcode to addressing mode and length decoder
// Assumes: combinational, one opcode in
// Notes: only opcode 00 returns mode AM_BAD; other undefined opcodes get the mode of their group
`timescale 1ns/10ps
`default_nettype none
module agf_decode (
  input wire logic [7:0] OPCODE,
  output agf_pkg::agf_dec_t DEC
);
  import agf_pkg::*;
  logic [3:0] hi;
  assign hi = OPCODE[7:4];
  always_comb begin
    DEC = '{mode: AM_BAD, len: 2'h1, acc_b: 1'b0, wide_imm: 1'b0, bitop: 1'b0};
    DEC.acc_b = OPCODE[6];
    unique case (hi)
      4'h0, 4'h1, 4'h3: begin
        if (OPCODE == 8'h00) begin
          DEC.mode = AM_BAD;
        end else begin
          DEC.mode = AM_INH; // RULE16
          DEC.len = 2'h1;
        end
      end
      4'h2: begin
        DEC.mode = AM_REL; // RULE17
        DEC.len = 2'h2;
      end
      4'h4, 4'h5: begin
        DEC.mode = AM_ACC; // RULE9
        DEC.len = 2'h1;
      end
      4'h6: begin
        DEC.mode = AM_IDX;
        DEC.bitop = (OPCODE == OP_AIM_IDX) || (OPCODE == OP_OIM_IDX) ||
                    (OPCODE == OP_EIM_IDX) || (OPCODE == OP_TIM_IDX);
        DEC.len = DEC.bitop ? 2'h3 : 2'h2; // RULE15
      end
      4'h7: begin
        DEC.bitop = (OPCODE == OP_AIM_DIR) || (OPCODE == OP_OIM_DIR) ||
                    (OPCODE == OP_EIM_DIR) || (OPCODE == OP_TIM_DIR);
        DEC.mode = DEC.bitop ? AM_DIR : AM_EXT; // RULE11
        DEC.len = 2'h3; // RULE12
      end
      4'h8, 4'hC: begin
        DEC.mode = AM_IMM; // RULE10
        DEC.wide_imm = (OPCODE == OP_LDS_IMM) || (OPCODE == OP_LDX_IMM) || (OPCODE == 8'hC3);
        DEC.len = DEC.wide_imm ? 2'h3 : 2'h2;
      end
      4'h9, 4'hD: begin
        DEC.mode = AM_DIR;
        DEC.len = 2'h2;
      end
      4'hA, 4'hE: begin
        DEC.mode = AM_IDX;
        DEC.len = 2'h2;
      end
      4'hB, 4'hF: begin
        DEC.mode = AM_EXT;
        DEC.len = 2'h3;
      end
    endcase
  end
endmodule : agf_decode
`default_nettype wire

// ### hdl/agf_core.sv
// Purpose: cpu front end: address generation, fetch trap, mask timing
// Assumes: memory answers every request in the next cycle with MEM_RDATA
// Notes: executes only the effective-address part of each instruction
// Function
// [RULE1] undefined opcode stacks registers like interrupt, vectors from FFEE/FFEF; code traps only opcode 00
// [RULE2] fetch trap outranks every interrupt, below only reset
// [RULE3] opcode fetch from 0000..001F raises the same trap
// [RULE4] address check applies to opcode fetches only, not data access
// [RULE5] fetches from empty external memory raise nothing
// [RULE6] stacked return address is the faulting fetch address
// [RULE7] D is A high and B low; writing D overwrites both
// [RULE8] seven addressing modes chosen by instruction type and opcode
// [RULE9] accumulator mode one byte, acts on A or B per opcode; code sets acc_b from opcode bit 6, which is 1 for both 4x and 5x
// [RULE10] immediate operand is byte two; stack/index loads take bytes two-three
// [RULE11] direct uses byte two as page-zero address; bit ops three bytes
// [RULE12] extended address is byte two high, byte three low
// [RULE13] indexed adds unsigned offset to index low byte, carry into high
// [RULE14] indexed address kept in temporary register, index unchanged
// [RULE15] indexed two bytes, four bit-manipulation ops three bytes
// [RULE16] implied one byte, target register fixed by opcode
// [RULE17] relative adds signed byte two to pc low, carry into high
// [RULE18] irq accepted between mask clear and set only after over 2 cycles; code counts the window in ST_ADDR states, not cycles
// [RULE19] same window applies when condition-code transfer changes the mask
// [RULE20] vector high byte from lower vector address, low from next
`timescale 1ns/10ps
`default_nettype none
module agf_core (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic IRQ_N,
  output agf_pkg::agf_bus_t MEM,
  input wire logic [7:0] MEM_RDATA,
  output logic [15:0] EA,
  output logic EA_VALID,
  output logic [2:0] EA_MODE,
  output logic TRAP_TAKEN,
  output logic IRQ_TAKEN,
  output logic [15:0] PC,
  output logic [15:0] IX,
  output logic [15:0] ACC_D,
  input wire logic D_WE,
  input wire logic [15:0] D_WDATA,
  input wire logic A_WE,
  input wire logic B_WE,
  input wire logic [7:0] AB_WDATA,
  input wire logic IX_WE,
  input wire logic [15:0] IX_WDATA,
  output logic IMASK
);
  import agf_pkg::*;

  typedef enum logic [3:0] {
    ST_RST0 = 4'h0,
    ST_RST1 = 4'h1,
    ST_FETCH = 4'h2,
    ST_DECODE = 4'h3,
    ST_OPND1 = 4'h4,
    ST_OPND2 = 4'h5,
    ST_ADDR = 4'h6,
    ST_STACK = 4'h7,
    ST_VECH = 4'h8,
    ST_VECL = 4'h9,
    ST_VECD = 4'hA
  } agf_state_t;

  agf_state_t state_q;
  logic [15:0] pc_q, op_pc_q, tmp_q, ix_q, sp_q, vec_q;
  logic [7:0] opc_q, b2_q, b3_q, acc_a_q, acc_b_q, ccr_q;
  logic [1:0] cnt_q;
  logic [2:0] stk_q;
  logic trap_q, irq_q, irq_pend;
  logic [1:0] win_q;
  logic mask_q;
  agf_dec_t dec_q, dec;
  agf_bus_t bus;
  logic [15:0] ea_d;
  logic [7:0] stk_byte;
  logic ea_valid_q, trap_taken_q, irq_taken_q;
  logic [15:0] ea_q;
  logic fetch_trap;
  logic cli_like, sei_like;

  agf_decode u_dec (
    .OPCODE(MEM_RDATA),
    .DEC(dec)
  );

  // address trap only looks at opcode fetches; empty external space is not seen
  assign fetch_trap = (MEM_RDATA == 8'h00) || (dec.mode == AM_BAD) ||
                      ((op_pc_q >= REG_SPACE_LO) && (op_pc_q <= REG_SPACE_HI)); // RULE3 RULE4 RULE5

  // a level request waits until the window after a mask clear has run out
  assign irq_pend = !IRQ_N && !mask_q && (win_q == 2'h0);

  // effective address per mode
  always_comb begin
    ea_d = 16'h0000;
    unique case (dec_q.mode)
      AM_DIR: ea_d = {8'h00, b2_q}; // RULE11
      AM_EXT: ea_d = {b2_q, b3_q}; // RULE12
      AM_IDX: ea_d = ix_q + {8'h00, (dec_q.bitop ? b3_q : b2_q)}; // RULE13
      AM_REL: ea_d = pc_q + {{8{b2_q[7]}}, b2_q}; // RULE17
      AM_IMM: ea_d = op_pc_q + 16'h0001; // RULE10
      AM_ACC, AM_INH, AM_BAD: ea_d = 16'h0000; // RULE9 RULE16
    endcase
  end

  always_comb begin
    unique case (stk_q)
      3'h0: stk_byte = op_pc_q[7:0]; // RULE6
      3'h1: stk_byte = op_pc_q[15:8];
      3'h2: stk_byte = ix_q[7:0];
      3'h3: stk_byte = ix_q[15:8];
      3'h4: stk_byte = acc_a_q;
      3'h5: stk_byte = acc_b_q;
      default: stk_byte = ccr_q;
    endcase
  end

  // read data lag their request by one state, so every read is issued one state early
  always_comb begin
    bus = '{req: 1'b0, addr: 16'h0000, fetch: 1'b0, wr: 1'b0, wdata: 8'h00};
    unique case (state_q)
      ST_RST0: begin
        bus.req = 1'b1;
        bus.addr = RESET_VEC;
      end
      ST_RST1: begin
        bus.req = 1'b1;
        bus.addr = RESET_VEC + 16'h0001;
      end
      ST_FETCH: begin
        bus.req = !(trap_q || irq_q);
        bus.addr = pc_q;
        bus.fetch = 1'b1; // RULE4
      end
      ST_DECODE: begin
        // byte two is requested while the opcode is decoded
        bus.req = 1'b1;
        bus.addr = pc_q;
      end
      ST_OPND1: begin
        // byte three, when there is one, is asked for while byte two arrives
        bus.req = (cnt_q == 2'h2);
        bus.addr = pc_q + 16'h0001;
      end
      ST_STACK: begin
        bus.req = 1'b1;
        bus.wr = 1'b1;
        bus.addr = sp_q;
        bus.wdata = stk_byte; // RULE1
      end
      ST_VECH: begin
        bus.req = 1'b1;
        bus.addr = vec_q; // RULE20
      end
      ST_VECL: begin
        bus.req = 1'b1;
        bus.addr = vec_q + 16'h0001; // RULE20
      end
      ST_OPND2, ST_ADDR, ST_VECD: bus.req = 1'b0;
    endcase
  end
  assign MEM = bus;

  // sequencer
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      state_q <= ST_RST0;
      pc_q <= 16'h0000;
      op_pc_q <= 16'h0000;
      opc_q <= 8'h00;
      b2_q <= 8'h00;
      b3_q <= 8'h00;
      cnt_q <= 2'h0;
      stk_q <= 3'h0;
      sp_q <= 16'h0000;
      vec_q <= 16'h0000;
      trap_q <= 1'b0;
      irq_q <= 1'b0;
      dec_q <= '{mode: AM_INH, len: 2'h1, acc_b: 1'b0, wide_imm: 1'b0, bitop: 1'b0};
    end else begin
      unique case (state_q)
        ST_RST0: begin
          state_q <= ST_RST1;
        end
        ST_RST1: begin
          // data of the request made in ST_RST0
          pc_q[15:8] <= MEM_RDATA;
          state_q <= ST_VECD;
        end
        ST_FETCH: begin
          op_pc_q <= pc_q;
          if (trap_q || irq_q) begin
            stk_q <= 3'h0;
            state_q <= ST_STACK;
          end else begin
            pc_q <= pc_q + 16'h0001;
            state_q <= ST_DECODE;
          end
        end
        ST_DECODE: begin
          opc_q <= MEM_RDATA;
          dec_q <= dec; // RULE8
          if (fetch_trap) begin
            trap_q <= 1'b1; // RULE2
            // rewind so the faulting address is stacked and retried
            pc_q <= op_pc_q; // RULE6
            vec_q <= TRAP_VEC_HI; // RULE1
            state_q <= ST_FETCH;
          end else if (dec.len == 2'h1) begin
            state_q <= ST_ADDR;
          end else begin
            cnt_q <= dec.len - 2'h1;
            state_q <= ST_OPND1;
          end
        end
        ST_OPND1: begin
          b2_q <= MEM_RDATA;
          pc_q <= pc_q + 16'h0001;
          state_q <= (cnt_q == 2'h2) ? ST_OPND2 : ST_ADDR;
        end
        ST_OPND2: begin
          b3_q <= MEM_RDATA;
          pc_q <= pc_q + 16'h0001;
          state_q <= ST_ADDR;
        end
        ST_ADDR: begin
          if (!trap_q && irq_pend) begin
            irq_q <= 1'b1;
            vec_q <= RESET_VEC - 16'h0008;
          end
          state_q <= ST_FETCH;
        end
        ST_STACK: begin
          sp_q <= sp_q - 16'h0001;
          stk_q <= stk_q + 3'h1;
          if (stk_q == 3'(STACK_BYTES - 1)) begin
            state_q <= ST_VECH;
          end
        end
        ST_VECH: begin
          // vector high byte arrives in ST_VECL
          state_q <= ST_VECL;
        end
        ST_VECL: begin
          pc_q[15:8] <= MEM_RDATA; // RULE20
          state_q <= ST_VECD;
        end
        ST_VECD: begin
          // reset load ends here too, with both flags already clear
          pc_q[7:0] <= MEM_RDATA; // RULE20
          trap_q <= 1'b0;
          irq_q <= 1'b0;
          state_q <= ST_FETCH;
        end
      endcase
    end
  end

  // interrupt mask and acceptance window after it is cleared
  assign cli_like = (state_q == ST_DECODE) && !fetch_trap &&
                    ((MEM_RDATA == OP_CLI) || ((MEM_RDATA == OP_TAP) && !acc_a_q[4]));
  assign sei_like = (state_q == ST_DECODE) && !fetch_trap &&
                    ((MEM_RDATA == OP_SEI) || ((MEM_RDATA == OP_TAP) && acc_a_q[4]));
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      mask_q <= 1'b1;
      win_q <= 2'h0;
      ccr_q <= 8'hD0;
    end else begin
      if (cli_like) begin
        mask_q <= 1'b0;
        win_q <= MASK_WINDOW_CYC; // RULE18 RULE19
      end else if (sei_like) begin
        mask_q <= 1'b1;
      end else if ((state_q == ST_STACK) && (stk_q == 3'(STACK_BYTES - 1))) begin
        mask_q <= 1'b1;
      end
      if (!cli_like && (state_q == ST_ADDR) && (win_q != 2'h0)) begin
        win_q <= win_q - 2'h1; // RULE18
      end
      ccr_q[4] <= mask_q;
    end
  end

  // accumulators: D is A:B
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      acc_a_q <= 8'h00;
      acc_b_q <= 8'h00;
    end else if (D_WE) begin
      acc_a_q <= D_WDATA[15:8]; // RULE7
      acc_b_q <= D_WDATA[7:0]; // RULE7
    end else begin
      if (A_WE) begin
        acc_a_q <= AB_WDATA;
      end
      if (B_WE) begin
        acc_b_q <= AB_WDATA;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ix_q <= 16'h0000;
    end else if (IX_WE) begin
      ix_q <= IX_WDATA; // RULE14
    end
  end

  // temporary address register and outputs
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      tmp_q <= 16'h0000;
      ea_q <= 16'h0000;
      ea_valid_q <= 1'b0;
      trap_taken_q <= 1'b0;
      irq_taken_q <= 1'b0;
    end else begin
      ea_valid_q <= (state_q == ST_ADDR);
      trap_taken_q <= (state_q == ST_VECD) && trap_q;
      irq_taken_q <= (state_q == ST_VECD) && irq_q && !trap_q;
      if (state_q == ST_ADDR) begin
        tmp_q <= ea_d; // RULE14
        ea_q <= ea_d;
      end
    end
  end

  assign EA = ea_q;
  assign EA_VALID = ea_valid_q;
  assign EA_MODE = dec_q.mode;
  assign TRAP_TAKEN = trap_taken_q;
  assign IRQ_TAKEN = irq_taken_q;
  assign PC = pc_q;
  assign IX = ix_q;
  assign ACC_D = {acc_a_q, acc_b_q}; // RULE7
  assign IMASK = mask_q;
endmodule : agf_core
`default_nettype wire

// ### verif/agf_core_props.sv
// Purpose: port-level checks for the fetch trap, vectors and registers
// Assumes: sees only the core's ports
// Notes: stack writes are counted from the last opcode fetch
`timescale 1ns/10ps
`default_nettype none
module agf_core_props (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire agf_pkg::agf_bus_t MEM,
  input wire logic [15:0] EA,
  input wire logic EA_VALID,
  input wire logic [2:0] EA_MODE,
  input wire logic TRAP_TAKEN,
  input wire logic IRQ_TAKEN,
  input wire logic [15:0] IX,
  input wire logic [15:0] ACC_D,
  input wire logic D_WE,
  input wire logic [15:0] D_WDATA,
  input wire logic A_WE,
  input wire logic B_WE,
  input wire logic [7:0] AB_WDATA,
  input wire logic IX_WE,
  input wire logic IMASK
);
  import agf_pkg::*;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  logic [3:0] wr_cnt_q;
  always_ff @(posedge REF_CLK) begin
    if (!RST_N || (MEM.req && MEM.fetch)) begin
      wr_cnt_q <= 4'h0;
    end else if (MEM.req && MEM.wr && wr_cnt_q != 4'hF) begin
      wr_cnt_q <= wr_cnt_q + 4'h1;
    end
  end
  sequence s_vec_hi;
    MEM.req && !MEM.wr && MEM.addr == TRAP_VEC_HI;
  endsequence
  sequence s_vec_lo;
    MEM.req && !MEM.wr && MEM.addr == TRAP_VEC_LO;
  endsequence
  a_regspace_fetch_trap: assert property (MEM.req && MEM.fetch && MEM.addr <= REG_SPACE_HI
    |-> ##[1:40] TRAP_TAKEN) else $error("register space fetch not trapped");
  a_vector_byte_order: assert property (s_vec_hi |-> ##[1:3] s_vec_lo)
    else $error("trap vector low byte not read after high byte");
  a_vector_then_trap: assert property (s_vec_lo |-> ##[1:4] TRAP_TAKEN)
    else $error("trap flag missing after vector read");
  a_trap_over_irq: assert property (!(TRAP_TAKEN && IRQ_TAKEN))
    else $error("trap and irq taken together");
  a_stack_seven_bytes: assert property ((TRAP_TAKEN || IRQ_TAKEN) |-> wr_cnt_q == 4'h7)
    else $error("stack write count wrong");
  a_direct_page_zero: assert property (EA_VALID && EA_MODE == AM_DIR |-> EA[15:8] == 8'h00)
    else $error("direct address outside page zero");
  a_double_acc_write: assert property (D_WE && !A_WE && !B_WE |=> ACC_D == $past(D_WDATA))
    else $error("double accumulator write lost");
  a_acc_a_high: assert property (A_WE && !D_WE |=> ACC_D[15:8] == $past(AB_WDATA))
    else $error("accumulator a not high byte");
  a_index_kept: assert property (EA_VALID && EA_MODE == AM_IDX && !$past(IX_WE) |-> $stable(IX))
    else $error("index changed by indexed address");
  a_reset_mask_set: assert property (disable iff (1'b0) !RST_N |=> IMASK)
    else $error("mask clear after reset");
endmodule : agf_core_props
bind agf_core agf_core_props u_props (.REF_CLK(REF_CLK), .RST_N(RST_N), .MEM(MEM), .EA(EA),
  .EA_VALID(EA_VALID), .EA_MODE(EA_MODE), .TRAP_TAKEN(TRAP_TAKEN), .IRQ_TAKEN(IRQ_TAKEN),
  .IX(IX), .ACC_D(ACC_D), .D_WE(D_WE), .D_WDATA(D_WDATA), .A_WE(A_WE), .B_WE(B_WE),
  .AB_WDATA(AB_WDATA), .IX_WE(IX_WE), .IMASK(IMASK));
`default_nettype wire

// ### verif/agf_mem_model.sv
// Purpose: program memory answering one cycle after each request
// Assumes: whole 64K space fitted, filled with no_operation_insn
// Notes: idle cycles invert the read bus; the last eight writes are logged in a ring
`timescale 1ns/10ps
`default_nettype none
module agf_mem_model (
  input wire logic clk,
  input wire logic clr,
  input wire agf_pkg::agf_bus_t bus,
  output logic [7:0] rdata
);
  import agf_pkg::*;
  logic [7:0] mem [0:65535];
  logic [7:0] wlog [0:7];
  int wr_count;
  initial begin
    foreach (mem[i]) mem[i] = 8'h01;
    rdata = 8'h00;
    wr_count = 0;
  end
  always @(posedge clk) begin
    if (clr) begin
      wr_count <= 0;
    end else if (bus.req && bus.wr) begin
      wlog[wr_count[2:0]] <= bus.wdata;
      wr_count <= wr_count + 1;
    end
    if (bus.req && bus.wr) begin
      mem[bus.addr] <= bus.wdata;
    end
    if (bus.req && !bus.wr) begin
      rdata <= mem[bus.addr];
    end else begin
      rdata <= ~rdata;
    end
  end
endmodule : agf_mem_model
`default_nettype wire

// ### verif/agf_core_test.sv
// Purpose: self-checking bench for the address generator and fetch trap
// Assumes: programs are poked into the memory model before boot releases reset
// Notes: every trap handler sits at 0200, the irq handler at 0A00
`timescale 1ns/10ps
`default_nettype none
module agf_core_test;
  import agf_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic irq_n = 1'b1;
  logic d_we = 1'b0;
  logic a_we = 1'b0;
  logic b_we = 1'b0;
  logic ix_we = 1'b0;
  logic [15:0] d_wdata = 16'h0000;
  logic [15:0] ix_wdata = 16'h0000;
  logic [7:0] ab_wdata = 8'h00;
  logic [7:0] mem_rdata;
  agf_bus_t mem_bus;
  logic [15:0] ea, pc, ix, acc_d;
  logic [2:0] ea_mode;
  logic ea_valid, trap_taken, irq_taken, imask;
  int bad_count = 0;
  int checked = 0;
  initial forever #12.5 ref_clk = ~ref_clk;
  agf_core dut (.REF_CLK(ref_clk), .RST_N(rst_n), .IRQ_N(irq_n), .MEM(mem_bus),
    .MEM_RDATA(mem_rdata), .EA(ea), .EA_VALID(ea_valid), .EA_MODE(ea_mode),
    .TRAP_TAKEN(trap_taken), .IRQ_TAKEN(irq_taken), .PC(pc), .IX(ix), .ACC_D(acc_d),
    .D_WE(d_we), .D_WDATA(d_wdata), .A_WE(a_we), .B_WE(b_we), .AB_WDATA(ab_wdata),
    .IX_WE(ix_we), .IX_WDATA(ix_wdata), .IMASK(imask));
  agf_mem_model u_mem (.clk(ref_clk), .clr(!rst_n), .bus(mem_bus), .rdata(mem_rdata));
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic put(input logic [15:0] a, input logic [7:0] b[$]);
    foreach (b[i]) u_mem.mem[a + 16'(i)] = b[i];
  endtask : put
  task automatic boot(input logic [15:0] start);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    put(RESET_VEC, '{start[15:8], start[7:0]});
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask : boot
  function automatic logic sig(input int which);
    return which == 0 ? ea_valid : (which == 1 ? trap_taken : irq_taken);
  endfunction : sig
  task automatic wait_hit(input int which);
    for (int i = 0; i < 200; i++) begin
      @(posedge ref_clk);
      #1;
      if (sig(which) === 1'b1) return;
    end
    chk(16'h0000, 16'h0001);
    wrap_up();
  endtask : wait_hit
  task automatic count_hits(input int which, input int n, output int hits);
    hits = 0;
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      if (sig(which) === 1'b1) hits++;
    end
  endtask : count_hits
  task automatic expect_ea(input agf_mode_t mode, input logic [15:0] addr);
    wait_hit(0);
    chk({13'h0000, ea_mode}, {13'h0000, mode});
    chk(ea, addr);
  endtask : expect_ea
  task automatic check_trap(input logic [15:0] addr);
    wait_hit(1);
    chk({u_mem.wlog[1], u_mem.wlog[0]}, addr);
    chk(16'(u_mem.wr_count), 16'h0007);
    chk(pc, 16'h0200);
  endtask : check_trap
  task automatic test_modes;
    int hits;
    put(16'h0100, '{8'hB6, 8'h12, 8'h34, 8'h96, 8'h80, 8'hA6, 8'hF0, 8'h20, 8'h02, 8'h01,
      8'h01, 8'h00});
    put(TRAP_VEC_HI, '{8'h02, 8'h00});
    put(16'h0200, '{8'h96, 8'h10, OP_LDX_IMM, 8'h12, 8'h34, OP_AIM_IDX, 8'hAA, 8'h10, 8'h4F,
      8'h01, 8'h86, 8'h55});
    boot(16'h0100);
    ix_we <= 1'b1;
    ix_wdata <= 16'h00F8;
    @(posedge ref_clk);
    ix_we <= 1'b0;
    expect_ea(AM_EXT, 16'h1234);
    expect_ea(AM_DIR, 16'h0080);
    expect_ea(AM_IDX, 16'h01E8);
    chk(ix, 16'h00F8);
    expect_ea(AM_REL, 16'h010B);
    check_trap(16'h010B);
    expect_ea(AM_DIR, 16'h0010);
    expect_ea(AM_IMM, 16'h0203);
    expect_ea(AM_IDX, 16'h0108);
    expect_ea(AM_ACC, 16'h0000);
    expect_ea(AM_INH, 16'h0000);
    expect_ea(AM_IMM, 16'h020B);
    count_hits(1, 20, hits);
    chk(16'(hits), 16'h0000);
    $display("test_modes done");
  endtask : test_modes
  task automatic test_regspace;
    int hits;
    boot(16'h0010);
    check_trap(16'h0010);
    boot(16'h0020);
    count_hits(1, 40, hits);
    chk(16'(hits), 16'h0000);
    $display("test_regspace done");
  endtask : test_regspace
  task automatic test_irq;
    int hits;
    put(16'hFFF6, '{8'h0A, 8'h00});
    put(16'h0400, '{OP_CLI, 8'h01, 8'h00});
    put(16'h0500, '{OP_CLI, OP_SEI});
    put(16'h0600, '{OP_CLI, 8'h01, OP_SEI});
    put(16'h0700, '{OP_CLI, 8'h01, 8'h01, OP_SEI});
    put(16'h0800, '{OP_TAP, 8'h01, OP_SEI});
    put(16'h0900, '{OP_TAP, 8'h01, 8'h01, OP_SEI});
    irq_n <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      boot(16'h0500 + 16'(k) * 16'h0100);
      count_hits(2, 40, hits);
      chk(16'(hits), (k == 2 || k == 4) ? 16'h0001 : 16'h0000);
    end
    boot(16'h0400);
    check_trap(16'h0402);
    count_hits(2, 20, hits);
    chk(16'(hits), 16'h0000);
    $display("test_irq done");
  endtask : test_irq
  task automatic test_acc;
    @(posedge ref_clk);
    d_we <= 1'b1;
    d_wdata <= 16'hA55A;
    @(posedge ref_clk);
    d_we <= 1'b0;
    a_we <= 1'b1;
    ab_wdata <= 8'h3C;
    #1 chk(acc_d, 16'hA55A);
    @(posedge ref_clk);
    a_we <= 1'b0;
    b_we <= 1'b1;
    ab_wdata <= 8'hC3;
    #1 chk(acc_d, 16'h3C5A);
    @(posedge ref_clk);
    b_we <= 1'b0;
    #1 chk(acc_d, 16'h3CC3);
    $display("test_acc done");
  endtask : test_acc
  initial begin
    test_modes();
    test_regspace();
    test_irq();
    test_acc();
    wrap_up();
  end
endmodule : agf_core_test
`default_nettype wire
